// ### rtl/slc_cfg.svh
// constants for the servo loop compensation block: offsets, fields, resets, timing
// assumes a 32-bit apb slave with byte addresses and a 50 mhz pclk
`ifndef SLC_CFG_SVH
`define SLC_CFG_SVH
`define SLC_A_CFG 8'h00
`define SLC_A_GRAV 8'h04
`define SLC_A_GAIN 8'h08
`define SLC_A_SPDTC 8'h0c
`define SLC_A_BLAMT 8'h10
`define SLC_A_GNUM 8'h14
`define SLC_A_GDEN 8'h18
`define SLC_A_STAT 8'h1c
`define SLC_A_CMD 8'h20
`define SLC_B_GRAV_EN 0
`define SLC_B_CMODE 4
`define SLC_B_SDET 8
`define SLC_B_BLDIR 12
`define SLC_B_RESTART 0
`define SLC_RST_CMODE 2'h1
`define SLC_CMODE_RSVD 2'h2
`define SLC_RST_GAIN 12'h7d0
`define SLC_GAIN_MIN 12'h064
`define SLC_GRAV_LIM 32'sh000003e8
`define SLC_BL_LIM 32'sh0007a120
`define SLC_RST_GEAR 16'h0001
`define SLC_BL_FRAC 40'h00_0000_000a
`define SLC_LIM_SCALE 58'h3a980
`define SLC_CLK_NS 20
`define SLC_TS_NS 10000
`define SLC_TS_CYC (`SLC_TS_NS / `SLC_CLK_NS)
`define SLC_TS_UNITS 40'h00_0000_0001
`endif

// ### rtl/slc_pkg.sv
// types shared by the servo loop compensation block
// assumes slc_cfg.svh carries the register, limit and timing constants; mode and state codes are defined here
package slc_pkg;
  typedef enum logic [1:0] {
    SLC_MODE_POS = 2'h0,
    SLC_MODE_SPD = 2'h1,
    SLC_MODE_TRQ = 2'h2
  } slc_ctrl_t;
  typedef enum logic [2:0] {
    SLC_S_IDLE = 3'h1,
    SLC_S_BL = 3'h2,
    SLC_S_FLT = 3'h4
  } slc_state_t;
endpackage : slc_pkg

// ### rtl/slc_div.sv
// serial unsigned restoring divider, one quotient bit per clock
// assumes the caller never divides by zero; both operands are taken at start
`timescale 1ns/1ps
`default_nettype none
module slc_div (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [39:0] dividend,
  input wire logic [39:0] divisor,
  output logic busy,
  output logic done,
  output logic [39:0] quotient
);
  logic [39:0] rem_r;
  // divisor held here: the caller's operand select moves on while dividing
  logic [39:0] dvs_r;
  logic [5:0] cnt_r;
  logic [40:0] trial;

  // shifted remainder stays below twice the divisor, so bit 40 is the borrow
  assign trial = {rem_r, quotient[39]} - {1'b0, dvs_r};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem_r <= 40'h00_0000_0000;
      dvs_r <= 40'h00_0000_0000;
      quotient <= 40'h00_0000_0000;
      cnt_r <= 6'h00;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      rem_r <= 40'h00_0000_0000;
      quotient <= dividend;
      dvs_r <= divisor;
      cnt_r <= 6'h28;
      busy <= 1'b1;
      done <= 1'b0;
    end else if (busy) begin
      if (!trial[40]) begin
        rem_r <= trial[39:0];
        quotient <= {quotient[38:0], 1'b1};
      end else begin
        rem_r <= {rem_r[38:0], quotient[39]};
        quotient <= {quotient[38:0], 1'b0};
      end
      cnt_r <= cnt_r - 6'h01;
      busy <= (cnt_r != 6'h01);
      done <= (cnt_r == 6'h01);
    end else begin
      done <= 1'b0;
    end
  end
endmodule : slc_div
`default_nettype wire

// ### rtl/slc_comp_top.sv
// servo loop compensation: gravity torque offset, current loop settings,
// speed feedback lag filter and backlash compensation, behind an apb slave
// assumes synchronous inputs on pclk (50 mhz) and pos_ref in encoder pulses
`timescale 1ns/1ps
`default_nettype none
`include "slc_cfg.svh"
module slc_comp_top import slc_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] ctrl_mode,
  input wire logic motor_rotary,
  input wire logic servo_on,
  input wire logic overtravel,
  input wire logic [15:0] motor_max_speed,
  input wire logic [25:0] encoder_res,
  input wire logic [31:0] pos_ref,
  input wire logic pos_ref_valid,
  output logic [31:0] pos_cmd,
  output logic pos_cmd_valid,
  input wire logic [15:0] torque_ref,
  output logic [16:0] torque_cmd,
  input wire logic [31:0] spd_fb,
  output logic [31:0] spd_fb_filt,
  output logic [1:0] cur_mode,
  output logic [11:0] cur_gain,
  output logic speed_det_method,
  output logic bl_active,
  output logic [31:0] bl_comp
);
  function automatic logic signed [31:0] sat(input logic signed [31:0] v,
                                             input logic signed [31:0] lim);
    if (v > lim) sat = lim;
    else if (v < -lim) sat = -lim;
    else sat = v;
  endfunction : sat
  function automatic logic [39:0] mag40(input logic signed [39:0] v);
    mag40 = v[39] ? 40'(-v) : v;
  endfunction : mag40
  // stored settings (software view)
  logic grav_en_r;
  logic [1:0] cmode_r;
  logic sdet_r;
  logic bldir_r;
  logic signed [10:0] grav_r;
  logic [11:0] gain_r;
  logic [15:0] spdtc_r;
  logic signed [20:0] blamt_r;
  logic [15:0] gnum_r;
  logic [15:0] gden_r;
  // settings in force since the last restart
  logic grav_en_act_r;
  logic bldir_act_r;
  logic restart;
  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  logic [31:0] rd_val;
  logic signed [31:0] wsat;
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wsat = $signed(pwdata);
  assign restart = wr_en & (paddr == `SLC_A_CMD) & pwdata[`SLC_B_RESTART];
  always_comb begin
    addr_ok = 1'b1;
    case (paddr)
      `SLC_A_CFG, `SLC_A_GRAV, `SLC_A_GAIN, `SLC_A_SPDTC,
      `SLC_A_BLAMT, `SLC_A_GNUM, `SLC_A_GDEN, `SLC_A_STAT, `SLC_A_CMD: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~addr_ok;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grav_en_r <= 1'b0;
      cmode_r <= `SLC_RST_CMODE;
      sdet_r <= 1'b0;
      bldir_r <= 1'b0;
    end else if (wr_en && paddr == `SLC_A_CFG) begin
      grav_en_r <= pwdata[`SLC_B_GRAV_EN];
      if (pwdata[`SLC_B_CMODE+1] == 1'b0) cmode_r <= pwdata[`SLC_B_CMODE +: 2];
      sdet_r <= pwdata[`SLC_B_SDET];
      bldir_r <= pwdata[`SLC_B_BLDIR];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grav_r <= 11'h000;
      gain_r <= `SLC_RST_GAIN;
      spdtc_r <= 16'h0000;
      blamt_r <= 21'h00_0000;
      gnum_r <= `SLC_RST_GEAR;
      gden_r <= `SLC_RST_GEAR;
    end else if (wr_en) begin
      case (paddr)
        `SLC_A_GRAV: grav_r <= 11'(sat(wsat, `SLC_GRAV_LIM));
        `SLC_A_GAIN: begin
          if (pwdata > 32'(`SLC_RST_GAIN)) gain_r <= `SLC_RST_GAIN;
          else if (pwdata < 32'(`SLC_GAIN_MIN)) gain_r <= `SLC_GAIN_MIN;
          else gain_r <= pwdata[11:0];
        end
        `SLC_A_SPDTC: spdtc_r <= pwdata[15:0];
        `SLC_A_BLAMT: blamt_r <= 21'(sat(wsat, `SLC_BL_LIM));
        // a zero gear denominator would divide by zero; zero in either gear term reads back as one
        `SLC_A_GNUM: gnum_r <= (pwdata[15:0] == 16'h0000) ? `SLC_RST_GEAR : pwdata[15:0];
        `SLC_A_GDEN: gden_r <= (pwdata[15:0] == 16'h0000) ? `SLC_RST_GEAR : pwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grav_en_act_r <= 1'b0;
      cur_mode <= `SLC_RST_CMODE;
      speed_det_method <= 1'b0;
      bldir_act_r <= 1'b0;
    end else if (restart) begin
      grav_en_act_r <= grav_en_r;
      cur_mode <= cmode_r;
      speed_det_method <= sdet_r;
      bldir_act_r <= bldir_r;
    end
  end
  assign cur_gain = gain_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) torque_cmd <= 17'h0_0000;
    else torque_cmd <= 17'($signed(torque_ref)) +
                       (grav_en_act_r ? 17'($signed(grav_r)) : 17'h0_0000);
  end
  // sample tick and shared divider sequencing
  logic [9:0] tick_cnt_r;
  logic tick;
  slc_state_t state_r;
  logic div_start;
  logic div_done;
  logic [39:0] div_q;
  logic [39:0] div_a;
  logic [39:0] div_b;
  logic signed [31:0] x_r;
  logic signed [32:0] diff;
  logic [39:0] bl_mag_r;
  logic bl_neg_r;
  assign tick = (tick_cnt_r == 10'(`SLC_TS_CYC - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick_cnt_r <= 10'h000;
    else tick_cnt_r <= tick ? 10'h000 : tick_cnt_r + 10'h001;
  end
  assign diff = {x_r[31], x_r} - {spd_fb_filt[31], spd_fb_filt};
  assign div_start = (state_r == SLC_S_IDLE && tick) || (state_r == SLC_S_BL && div_done);
  always_comb begin
    if (state_r == SLC_S_IDLE) begin
      div_a = 40'(mag40(40'(blamt_r))) * 40'(gnum_r);
      div_b = 40'(gden_r) * `SLC_BL_FRAC;
    end else begin
      // step equals diff times ts over tc plus ts
      div_a = 40'(diff[32] ? 33'(-diff) : diff) * `SLC_TS_UNITS;
      div_b = 40'(spdtc_r) + `SLC_TS_UNITS;
    end
  end

  slc_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .start(div_start),
    .dividend(div_a),
    .divisor(div_b),
    .busy(),
    .done(div_done),
    .quotient(div_q)
  );
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SLC_S_IDLE;
      x_r <= 32'sh0000_0000;
      spd_fb_filt <= 32'h0000_0000;
      bl_mag_r <= 40'h00_0000_0000;
      bl_neg_r <= 1'b0;
    end else begin
      case (state_r)
        SLC_S_IDLE: if (tick) begin
          x_r <= $signed(spd_fb);
          state_r <= SLC_S_BL;
        end
        SLC_S_BL: if (div_done) begin
          bl_mag_r <= div_q;
          bl_neg_r <= blamt_r[20];
          state_r <= SLC_S_FLT;
        end
        SLC_S_FLT: if (div_done) begin
          // lag update, zero tc passes through
          if (spdtc_r == 16'h0000) spd_fb_filt <= x_r;
          else if (diff[32]) spd_fb_filt <= spd_fb_filt - div_q[31:0];
          else spd_fb_filt <= spd_fb_filt + div_q[31:0];
          state_r <= SLC_S_IDLE;
        end
        default: state_r <= SLC_S_IDLE;
      endcase
    end
  end
  // backlash path
  logic bl_lim_ok;
  logic bl_on;
  logic signed [31:0] bl_pulses;
  logic signed [31:0] delta;
  logic signed [31:0] pos_prev_r;
  logic mv_same;
  logic mv_opp;
  logic [31:0] comp_nxt;
  // limit in pulses, 60 over 0.00025 folded
  assign bl_lim_ok = (58'(bl_mag_r) * `SLC_LIM_SCALE) <=
                     (58'(motor_max_speed) * 58'(encoder_res));
  assign bl_pulses = bl_neg_r ? -$signed(bl_mag_r[31:0]) : $signed(bl_mag_r[31:0]);
  assign bl_on = (ctrl_mode == SLC_MODE_POS) & motor_rotary & servo_on & ~overtravel
                 & bl_lim_ok;
  assign delta = $signed(pos_ref) - pos_prev_r;
  assign mv_same = bldir_act_r ? (delta < 0) : (delta > 0);
  assign mv_opp = bldir_act_r ? (delta > 0) : (delta < 0);

  always_comb begin
    comp_nxt = bl_comp;
    if (!bl_on) comp_nxt = 32'h0000_0000;
    else if (pos_ref_valid && mv_same) comp_nxt = bl_pulses;
    else if (pos_ref_valid && mv_opp) comp_nxt = 32'h0000_0000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bl_comp <= 32'h0000_0000;
      pos_prev_r <= 32'sh0000_0000;
      pos_cmd <= 32'h0000_0000;
      pos_cmd_valid <= 1'b0;
    end else begin
      bl_comp <= comp_nxt;
      pos_cmd_valid <= pos_ref_valid;
      if (pos_ref_valid) begin
        pos_prev_r <= $signed(pos_ref);
        pos_cmd <= pos_ref + comp_nxt;
      end
    end
  end
  assign bl_active = (bl_comp != 32'h0000_0000);

  // read data registered in the setup phase so prdata comes from a flop
  always_comb begin
    case (paddr)
      `SLC_A_CFG: rd_val = 32'({bldir_r, 3'h0, sdet_r, 2'h0, cmode_r, 3'h0, grav_en_r});
      `SLC_A_GRAV: rd_val = 32'($signed(grav_r));
      `SLC_A_GAIN: rd_val = 32'(gain_r);
      `SLC_A_SPDTC: rd_val = 32'(spdtc_r);
      `SLC_A_BLAMT: rd_val = 32'($signed(blamt_r));
      `SLC_A_GNUM: rd_val = 32'(gnum_r);
      `SLC_A_GDEN: rd_val = 32'(gden_r);
      `SLC_A_STAT: rd_val = 32'({bl_lim_ok, bl_active, bldir_act_r, speed_det_method,
                                 cur_mode, grav_en_act_r});
      default: rd_val = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (rd_setup) prdata <= rd_val;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_grav_restart;
    $changed(grav_en_act_r) |-> $past(restart);
  endproperty
  a_grav_restart: assert property (p_grav_restart) else $error("enable moved early");
  property p_grav_range;
    (grav_r <= 11'sd1000) && (grav_r >= -11'sd1000);
  endproperty
  a_grav_range: assert property (p_grav_range) else $error("gravity out of range");
  property p_cmode;
    (cur_mode != `SLC_CMODE_RSVD) && !($changed(cur_mode) && !$past(restart));
  endproperty
  a_cmode: assert property (p_cmode) else $error("current mode bad");
  property p_gain;
    wr_en && paddr == `SLC_A_GAIN && pwdata == 32'h0000_03e8 |=> cur_gain == 12'h3e8;
  endproperty
  a_gain: assert property (p_gain) else $error("gain not immediate");
  property p_sdet;
    $changed(speed_det_method) |-> $past(restart);
  endproperty
  a_sdet: assert property (p_sdet) else $error("method moved early");
  property p_filt_pass;
    state_r == SLC_S_FLT && div_done && spdtc_r == 16'h0000 |=> spd_fb_filt == $past(x_r);
  endproperty
  a_filt_pass: assert property (p_filt_pass) else $error("no pass-through");
  property p_sum;
    pos_ref_valid |=> pos_cmd == 32'($past(pos_ref) + bl_comp);
  endproperty
  a_sum: assert property (p_sum) else $error("bad position sum");
  property p_mode;
    ctrl_mode != SLC_MODE_POS || !motor_rotary |=> bl_comp == 32'h0000_0000;
  endproperty
  a_mode: assert property (p_mode) else $error("backlash off-mode");
  property p_amt;
    (blamt_r <= 21'sd500000) && (blamt_r >= -21'sd500000);
  endproperty
  a_amt: assert property (p_amt) else $error("amount out of range");
  property p_limit;
    !bl_lim_ok |=> bl_comp == 32'h0000_0000;
  endproperty
  a_limit: assert property (p_limit) else $error("backlash over limit");
  property p_opp;
    pos_ref_valid && mv_opp |=> bl_comp == 32'h0000_0000;
  endproperty
  a_opp: assert property (p_opp) else $error("backlash on reverse");
  property p_off;
    !servo_on || overtravel ##0 pos_ref_valid |=> pos_cmd == $past(pos_ref);
  endproperty
  a_off: assert property (p_off) else $error("backlash not paused");
  property p_torque;
    grav_en_act_r |=> torque_cmd == 17'($signed($past(torque_ref))) + 17'($signed($past(grav_r)));
  endproperty
  a_torque: assert property (p_torque) else $error("gravity offset lost");

  c_restart: cover property (restart ##1 grav_en_act_r);
  c_bl_apply: cover property (pos_ref_valid && mv_same && bl_on ##1 bl_active);
  c_bl_drop: cover property (bl_active ##1 pos_ref_valid && mv_opp ##1 !bl_active);
  c_filter: cover property (state_r == SLC_S_FLT && div_done && spdtc_r != 16'h0000);
endmodule : slc_comp_top
`default_nettype wire

// ### sim/slc_host_model.sv
// host motion controller model: turns a bench request into one position reference
// assumes requests arrive from the bench right after a rising edge of pclk
`timescale 1ns/1ps
`default_nettype none
module slc_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic send,
  input wire logic [31:0] target,
  output logic [31:0] pos_ref,
  output logic pos_ref_valid
);
  // data lines toggle outside valid cycles, so a stale value never passes as a reference
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_ref <= 32'h0000_0000;
      pos_ref_valid <= 1'b0;
    end else if (send) begin
      pos_ref <= target;
      pos_ref_valid <= 1'b1;
    end else begin
      pos_ref <= ~pos_ref;
      pos_ref_valid <= 1'b0;
    end
  end
endmodule : slc_host_model
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for slc_comp_top: apb settings, gravity, current, speed filter, backlash
// assumes slc_host_model stands in for the host that issues position references
`timescale 1ns/1ps
`default_nettype none
`include "slc_cfg.svh"
module tb_top import slc_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, pos_ref, pos_cmd, spd_fb, spd_fb_filt, bl_comp, target;
  logic [1:0] ctrl_mode, cur_mode;
  logic motor_rotary, servo_on, overtravel, pos_ref_valid, pos_cmd_valid, send;
  logic speed_det_method, bl_active;
  logic [15:0] motor_max_speed, torque_ref;
  logic [25:0] encoder_res;
  logic [16:0] torque_cmd;
  logic [11:0] cur_gain;
  int error_cnt, total_checks;

  slc_comp_top slc_comp_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ctrl_mode(ctrl_mode), .motor_rotary(motor_rotary),
    .servo_on(servo_on), .overtravel(overtravel), .motor_max_speed(motor_max_speed),
    .encoder_res(encoder_res), .pos_ref(pos_ref), .pos_ref_valid(pos_ref_valid),
    .pos_cmd(pos_cmd), .pos_cmd_valid(pos_cmd_valid), .torque_ref(torque_ref),
    .torque_cmd(torque_cmd), .spd_fb(spd_fb), .spd_fb_filt(spd_fb_filt),
    .cur_mode(cur_mode), .cur_gain(cur_gain), .speed_det_method(speed_det_method),
    .bl_active(bl_active), .bl_comp(bl_comp));
  slc_host_model slc_host_model_inst (.pclk(pclk), .presetn(presetn), .send(send),
    .target(target), .pos_ref(pos_ref), .pos_ref_valid(pos_ref_valid));

  always #10 pclk = ~pclk;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("pready wait", 32'h1, 32'(n));
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // restart stands in for a power cycle of the stored settings
  task automatic restart();
    apb(1'b1, `SLC_A_CMD, 32'h0000_0001);
    repeat (3) @(negedge pclk);
  endtask : restart

  task automatic send_ref(input logic [31:0] v, input logic [31:0] ecmd, input logic [31:0] ebl);
    int n;
    @(posedge pclk);
    send <= 1'b1;
    target <= v;
    @(posedge pclk);
    send <= 1'b0;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (pos_cmd_valid !== 1'b1 && n < 8);
    chk("pos_cmd_valid", 32'h1, {31'h0, pos_cmd_valid});
    chk("pos_cmd", ecmd, pos_cmd);
    chk("bl_comp", ebl, bl_comp);
    chk("bl_active", {31'h0, ebl != 32'h0}, {31'h0, bl_active});
    @(negedge pclk);
    chk("pos_cmd_valid", 32'h0, {31'h0, pos_cmd_valid});
  endtask : send_ref

  task automatic t_reset();
    chk("cur_gain", `SLC_RST_GAIN, cur_gain);
    chk("cur_mode", `SLC_RST_CMODE, cur_mode);
    chk("speed_det_method", 32'h0, speed_det_method);
    chk("torque_cmd", 32'h0000_0064, torque_cmd);
  endtask : t_reset

  task automatic t_gain();
    apb(1'b1, `SLC_A_GAIN, 32'h0000_03e8);
    @(negedge pclk);
    chk("cur_gain", 32'h0000_03e8, cur_gain);
    apb(1'b1, `SLC_A_GAIN, 32'h0000_0032);
    @(negedge pclk);
    chk("cur_gain", `SLC_GAIN_MIN, cur_gain);
    apb(1'b0, `SLC_A_GAIN, 32'h0);
    chk("gain readback", 32'h0000_0064, rd);
  endtask : t_gain

  task automatic t_config();
    apb(1'b1, `SLC_A_GRAV, 32'h0000_012c);
    apb(1'b1, `SLC_A_CFG, 32'h0000_0101);
    repeat (2) @(negedge pclk);
    chk("torque_cmd", 32'h0000_0064, torque_cmd);
    chk("cur_mode", 32'h1, cur_mode);
    chk("speed_det_method", 32'h0, speed_det_method);
    restart();
    chk("torque_cmd", 32'h0000_0190, torque_cmd);
    chk("cur_mode", 32'h0, cur_mode);
    chk("speed_det_method", 32'h1, speed_det_method);
    apb(1'b1, `SLC_A_CFG, 32'h0000_0121);
    restart();
    chk("cur_mode", 32'h0, cur_mode);
    apb(1'b1, `SLC_A_GRAV, 32'h0000_07d0);
    repeat (2) @(negedge pclk);
    chk("torque_cmd", 32'h0000_044c, torque_cmd);
    apb(1'b1, `SLC_A_GRAV, 32'hffff_fc18);
    repeat (2) @(negedge pclk);
    chk("torque_cmd", 32'h0001_fc7c, torque_cmd);
    apb(1'b1, `SLC_A_CFG, 32'h0000_0000);
    restart();
    chk("torque_cmd", 32'h0000_0064, torque_cmd);
  endtask : t_config

  task automatic t_speed();
    int n;
    @(posedge pclk);
    spd_fb <= 32'h0000_04d2;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (spd_fb_filt !== 32'h0000_04d2 && n < 1200);
    chk("spd_fb_filt", 32'h0000_04d2, spd_fb_filt);
    apb(1'b1, `SLC_A_SPDTC, 32'h0000_0001);
    spd_fb <= 32'h0;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (spd_fb_filt === 32'h0000_04d2 && n < 1200);
    chk("spd_fb_filt", 32'h0000_0269, spd_fb_filt);
  endtask : t_speed

  task automatic t_backlash();
    apb(1'b1, `SLC_A_BLAMT, 32'h0001_0000);
    // the amount is converted once per sample period, so let one pass
    repeat (600) @(posedge pclk);
    send_ref(32'h0000_03e8, 32'h0000_1d81, 32'h0000_1999);
    send_ref(32'h0000_01f4, 32'h0000_01f4, 32'h0);
    send_ref(32'h0000_0320, 32'h0000_1cb9, 32'h0000_1999);
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk);
      case (i)
        0: servo_on <= 1'b0;
        1: ctrl_mode <= SLC_MODE_SPD;
        2: overtravel <= 1'b1;
        3: motor_max_speed <= 16'h03e8;
        4: motor_rotary <= 1'b0;
        default: ctrl_mode <= SLC_MODE_TRQ;
      endcase
      repeat (3) @(negedge pclk);
      send_ref(32'h0000_0600 + 32'(i), 32'h0000_0600 + 32'(i), 32'h0);
      @(posedge pclk);
      servo_on <= 1'b1;
      ctrl_mode <= SLC_MODE_POS;
      overtravel <= 1'b0;
      motor_max_speed <= 16'h1770;
      motor_rotary <= 1'b1;
    end
    send_ref(32'h0000_0700, 32'h0000_2099, 32'h0000_1999);
    apb(1'b1, `SLC_A_CFG, 32'h0000_1000);
    restart();
    send_ref(32'hffff_ec78, 32'h0000_0611, 32'h0000_1999);
    send_ref(32'h0000_07d0, 32'h0000_07d0, 32'h0);
  endtask : t_backlash

  task automatic t_apb_err();
    apb(1'b0, 8'h24, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    chk("prdata", 32'h0, rd);
  endtask : t_apb_err

  task automatic complete_run();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, send, overtravel} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    target = 32'h0;
    ctrl_mode = SLC_MODE_POS;
    motor_rotary = 1'b1;
    servo_on = 1'b1;
    motor_max_speed = 16'h1770;
    encoder_res = 26'h010_0000;
    torque_ref = 16'h0064;
    spd_fb = 32'h0;
    error_cnt = 0;
    total_checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(negedge pclk);
    t_reset();
    t_gain();
    t_config();
    t_speed();
    t_backlash();
    t_apb_err();
    complete_run();
  end

  // the scenarios need a few thousand cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
